// ### hdl/schbp_top.v
// Host parallel bus port: register select, tri-state data, strobes,
// wait ready, interrupt request and acknowledge vector.
// Assumes all host pins are synchronous to sys_clk; pins are split
// into input, output and enable since no wire is resolved here.
`timescale 1ns/1ps
`include "schbp_defs.vh"
module schbp_top (
   // Clock and reset.
   input wire sys_clk,
   input wire rst,
   // Host bus pins.
   input wire [5:0] reg_select_addr,
   input wire [7:0] host_data_bus_in,
   output reg [7:0] host_data_bus_out,
   output wire host_data_bus_oe,
   input wire host_read_strobe_n,
   input wire host_write_strobe_n,
   input wire chip_select_n,
   input wire interrupt_ack_n,
   input wire dma_ack_n,
   // Open-drain outputs: output held low, enable pulls.
   output wire wait_ready_n_out,
   output wire wait_ready_n_oe,
   output wire interrupt_request_n_out,
   output wire interrupt_request_n_oe,
   // Configuration.
   input wire [1:0] wait_mode,
   input wire vector_by_status,
   input wire [1:0] ack_kind,
   input wire dma_rx_dir,
   // Queue status and interrupt sources.
   input wire receive_queue_has_data,
   input wire transmit_queue_has_room,
   input wire [7:0] int_cond,
   input wire [7:0] int_enable,
   input wire [7:0] rx_queue_data,
   // Queue side strobes.
   output wire rx_queue_pop,
   output wire tx_queue_push,
   output reg [7:0] tx_queue_data,
   // Internal timing tick.
   output reg timing_tick
);
   // =====================================================================
   // Local state.
   localparam ST_IDLE = 3'b001;
   localparam ST_READ = 3'b010;
   localparam ST_WRITE = 3'b100;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg wait_reg;
   reg [2:0] cnt_reg;
   reg [7:0] wr_latch_reg;
   reg [5:0] addr_latch_reg;
   wire rd_fall;
   wire rd_rise;
   wire wr_fall;
   wire wr_rise;
   wire [7:0] reg_rd_data;
   wire [7:0] pending;
   wire any_pending;
   wire cs_act;
   wire rd_act;
   wire ack_act;
   wire dma_act;
   wire wait_rx_on;
   wire wait_tx_on;
   wire rd_blocked;
   wire wr_blocked;
   wire reg_wr_pulse;
   wire rd_is_rxq;
   wire wr_is_txq;
   wire tx_take;
   reg cs_prev_reg;
   reg dma_prev_reg;
   reg [7:0] vector_val;
   reg [2:0] vec_code;
   integer k;

   // =====================================================================
   // Strobe edges.
   schbp_edge u_rd_edge (
      .sys_clk(sys_clk),
      .rst(rst),
      .strobe_n(host_read_strobe_n),
      .fall_pulse(rd_fall),
      .rise_pulse(rd_rise)
   );
   schbp_edge u_wr_edge (
      .sys_clk(sys_clk),
      .rst(rst),
      .strobe_n(host_write_strobe_n),
      .fall_pulse(wr_fall),
      .rise_pulse(wr_rise)
   );

   // Qualified strobes; no register read or write happens without chip select.
   // An acknowledge or DMA cycle drives the bus with select high, so those
   // terms are kept apart from the register path.
   assign cs_act = ~chip_select_n;
   assign rd_act = cs_act & ~host_read_strobe_n;
   assign ack_act = ~interrupt_ack_n;
   assign dma_act = ~dma_ack_n & dma_rx_dir & ~host_read_strobe_n;
   assign rd_is_rxq = (reg_select_addr == `SCHBP_ADDR_RXQ);
   assign wr_is_txq = (addr_latch_reg == `SCHBP_ADDR_TXQ);

   // =====================================================================
   // Blocking conditions for the wait modes.
   // Only the two queue addresses can stall; every other register answers at
   // once, so a wait mode never holds up a status or vector read.
   assign wait_rx_on = (wait_mode == `SCHBP_WAIT_RX) | (wait_mode == `SCHBP_WAIT_BOTH);
   assign wait_tx_on = (wait_mode == `SCHBP_WAIT_TX) | (wait_mode == `SCHBP_WAIT_BOTH);
   assign rd_blocked = wait_rx_on & rd_is_rxq & ~receive_queue_has_data;
   assign wr_blocked = wait_tx_on & (reg_select_addr == `SCHBP_ADDR_TXQ)
                       & ~transmit_queue_has_room;

   // Cycle tracker; a write is held until its room opens up.
   // A strobe that falls without select leaves the tracker idle, so the
   // matching rise is ignored as well.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cs_act && rd_fall) begin
               state_next = ST_READ;
            end else if (cs_act && wr_fall) begin
               state_next = ST_WRITE;
            end
         end
         ST_READ: begin
            if (rd_rise) begin
               state_next = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (wr_rise) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State, wait flag and write latch; reset needs no clock edge.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         wait_reg <= 1'b0;
         wr_latch_reg <= `SCHBP_ZERO8;
         addr_latch_reg <= `SCHBP_ZERO6;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE && cs_act && rd_fall) begin
            wait_reg <= rd_blocked;
         end else if (state_reg == ST_IDLE && cs_act && wr_fall) begin
            wait_reg <= wr_blocked;
         end else if (state_reg == ST_READ && wait_reg && !rd_blocked) begin
            wait_reg <= 1'b0;
         end else if (state_reg == ST_WRITE && wait_reg && !wr_blocked) begin
            wait_reg <= 1'b0;
         end else if (state_reg == ST_IDLE || wait_mode == `SCHBP_WAIT_OFF) begin
            wait_reg <= 1'b0;
         end
         if (state_reg == ST_WRITE || (state_reg == ST_IDLE && cs_act && wr_fall)) begin
            wr_latch_reg <= host_data_bus_in;
            addr_latch_reg <= reg_select_addr;
         end
      end
   end

   // Ready is only pulled during an active, blocked cycle.
   assign wait_ready_n_out = 1'b0;
   assign wait_ready_n_oe = wait_reg & (state_reg != ST_IDLE)
                            & (wait_mode != `SCHBP_WAIT_OFF);

   // =====================================================================
   // Register file; capture at the write strobe rising edge.
   // Select is qualified from the last cycle in which the strobe was low.
   assign reg_wr_pulse = (state_reg == ST_WRITE) & wr_rise & cs_prev_reg & ~wr_is_txq;
   schbp_regs u_regs (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_pulse(reg_wr_pulse),
      .wr_addr(addr_latch_reg),
      .wr_data(wr_latch_reg),
      .rd_addr(reg_select_addr),
      .rd_data(reg_rd_data)
   );

   // Select and DMA acknowledge as they stood in the last cycle of the strobe.
   // The trailing edge is seen in the first cycle the pin is high, and a host that
   // lifts select together with its strobe must not lose the transfer, so the
   // qualifier comes from the cycle before the edge is reported.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_prev_reg <= 1'b0;
         dma_prev_reg <= 1'b0;
      end else begin
         cs_prev_reg <= cs_act;
         dma_prev_reg <= ~dma_ack_n & dma_rx_dir;
      end
   end

   // Queue strobes happen at the trailing edge so one cycle moves one byte.
   // A write that was stalled pushes only after its ready has been released.
   assign tx_take = (state_reg == ST_WRITE) & wr_rise & cs_prev_reg & wr_is_txq;
   assign tx_queue_push = tx_take & ~wait_reg;
   // The DMA pop uses the acknowledge of the previous cycle: by the time the
   // read strobe's rise is reported, the pin-level acknowledge may be gone.
   assign rx_queue_pop = ((state_reg == ST_READ) & rd_rise & rd_is_rxq & ~wait_reg)
                         | (dma_prev_reg & rd_rise);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_queue_data <= `SCHBP_ZERO8;
      end else if (tx_take) begin
         tx_queue_data <= wr_latch_reg;
      end
   end

   // =====================================================================
   // Interrupts: pending causes and the open-drain request.
   assign pending = int_cond & int_enable;
   assign any_pending = |pending;
   assign interrupt_request_n_out = 1'b0;
   assign interrupt_request_n_oe = any_pending;

   // Vector code is the index of the highest pending cause.
   always @* begin
      vec_code = `SCHBP_ZERO3;
      for (k = 0; k < `SCHBP_DATA_W; k = k + 1) begin
         if (pending[k]) begin
            vec_code = k[2:0];
         end
      end
   end

   // Fixed vector, or its low bits replaced by the cause code.
   always @* begin
      if (vector_by_status) begin
         vector_val = {reg_rd_data[7:`SCHBP_VEC_LOW_W], vec_code};
      end else begin
         vector_val = reg_rd_data;
      end
   end

   // =====================================================================
   // Data bus drive. The vector register is read during acknowledge,
   // so the address must point at it; this keeps one read port only.
   assign host_data_bus_oe = (rd_act & ~ack_act)
                             | (ack_act & any_pending & (ack_kind != `SCHBP_ACK_FLOAT))
                             | dma_act;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         host_data_bus_out <= `SCHBP_ZERO8;
      end else if (ack_act) begin
         case (ack_kind)
            `SCHBP_ACK_VEC: host_data_bus_out <= vector_val;
            `SCHBP_ACK_CALL: host_data_bus_out <= `SCHBP_CALL_OP;
            default: host_data_bus_out <= `SCHBP_ZERO8;
         endcase
      end else if (dma_act || (rd_act && rd_is_rxq)) begin
         host_data_bus_out <= rx_queue_data;
      end else if (reg_select_addr == `SCHBP_ADDR_GSR) begin
         host_data_bus_out <= pending;
      end else begin
         host_data_bus_out <= reg_rd_data;
      end
   end

   // =====================================================================
   // Timing tick from the device clock, feeding bit rate logic elsewhere.
   // The tick is registered so that no consumer sees a decode glitch.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= `SCHBP_ZERO3;
         timing_tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + `SCHBP_ONE3;
         timing_tick <= (cnt_reg == `SCHBP_PRESCALE);
      end
   end
endmodule

// ### hdl/schbp_defs.vh
// Constants for the host bus port of the dual-channel serial controller.
// Assumes inclusion by bare name from the design files of the block that use it.
`ifndef SCHBP_DEFS_VH
`define SCHBP_DEFS_VH
`define SCHBP_DATA_W 8
`define SCHBP_ADDR_W 6
`define SCHBP_ZERO8 8'h00
`define SCHBP_ZERO6 6'h00
`define SCHBP_ZERO3 3'h0
`define SCHBP_ONE3 3'h1
// Register indices that the port treats specially.
`define SCHBP_ADDR_RXQ 6'h1B
`define SCHBP_ADDR_TXQ 6'h1A
`define SCHBP_ADDR_GSR 6'h1F
`define SCHBP_ADDR_IVEC 6'h1C
// Wait mode encodings.
`define SCHBP_WAIT_OFF 2'h0
`define SCHBP_WAIT_RX 2'h1
`define SCHBP_WAIT_TX 2'h2
`define SCHBP_WAIT_BOTH 2'h3
// Acknowledge response kinds.
`define SCHBP_ACK_VEC 2'h0
`define SCHBP_ACK_CALL 2'h1
`define SCHBP_ACK_ZERO 2'h2
`define SCHBP_ACK_FLOAT 2'h3
`define SCHBP_CALL_OP 8'hCD
`define SCHBP_VEC_LOW_W 3
`define SCHBP_CNT_W 3
`define SCHBP_PRESCALE 3'h7
`endif

// ### hdl/schbp_edge.v
// Edge detector for an active-low strobe already synchronous to sys_clk.
// Assumes the strobe is free of glitches and idles high.
`timescale 1ns/1ps
module schbp_edge (
   // Clock and reset.
   input wire sys_clk,
   input wire rst,
   // Strobe in and edge pulses out.
   input wire strobe_n,
   output wire fall_pulse,
   output wire rise_pulse
);
   reg prev_reg;
   // =====================================================================
   // Previous level, idle high after reset.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= strobe_n;
      end
   end
   // Pulses last one cycle each.
   assign fall_pulse = prev_reg & ~strobe_n;
   assign rise_pulse = ~prev_reg & strobe_n;
endmodule

// ### hdl/schbp_regs.v
// Register array reached through the host port.
// Assumes writes come as one-cycle pulses from the bus port.
`timescale 1ns/1ps
`include "schbp_defs.vh"
module schbp_regs (
   // Clock and reset.
   input wire sys_clk,
   input wire rst,
   // Access.
   input wire wr_pulse,
   input wire [5:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [5:0] rd_addr,
   output wire [7:0] rd_data
);
   reg [7:0] mem_reg [0:63];
   genvar i;
   // =====================================================================
   // One entry per register; reset clears each one.
   generate
      for (i = 0; i < 64; i = i + 1) begin : g_ent
         localparam [5:0] ENT_IDX = i;
         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               mem_reg[i] <= `SCHBP_ZERO8;
            end else if (wr_pulse && wr_addr == ENT_IDX) begin
               mem_reg[i] <= wr_data;
            end
         end
      end
   endgenerate
   assign rd_data = mem_reg[rd_addr];
endmodule

// ### test/schbp_checker_sva.sv
// Concurrent checks on the host bus port, seen from its top-level ports only.
// Assumes one clock domain, sys_clk, and the asynchronous active-high rst.
`timescale 1ns/1ps
module schbp_checker (
   // Clock and reset.
   input wire sys_clk,
   input wire rst,
   // Host side.
   input wire [5:0] reg_select_addr,
   input wire [7:0] host_data_bus_out,
   input wire host_data_bus_oe,
   input wire host_read_strobe_n,
   input wire host_write_strobe_n,
   input wire chip_select_n,
   input wire interrupt_ack_n,
   input wire dma_ack_n,
   input wire wait_ready_n_oe,
   input wire interrupt_request_n_oe,
   // Configuration and queue side.
   input wire [1:0] wait_mode,
   input wire [7:0] int_cond,
   input wire [7:0] int_enable,
   input wire receive_queue_has_data,
   input wire transmit_queue_has_room,
   input wire rx_queue_pop,
   input wire tx_queue_push,
   input wire timing_tick
);
   // ========================================
   // Port properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rd_oe;
      !chip_select_n && !host_read_strobe_n && wait_mode == 2'h0 |-> host_data_bus_oe;
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("read cycle left data bus floating");
   property p_float;
      chip_select_n && interrupt_ack_n && dma_ack_n |-> !host_data_bus_oe;
   endproperty
   a_float: assert property (p_float) else $error("data bus driven without select");
   property p_irq;
      interrupt_request_n_oe == |(int_cond & int_enable);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request wrong");
   property p_rdy_off;
      wait_mode == 2'h0 && $past(wait_mode) == 2'h0 |-> !wait_ready_n_oe;
   endproperty
   a_rdy_off: assert property (p_rdy_off) else $error("ready active with no wait mode");
   property p_rdy_idle;
      host_read_strobe_n && host_write_strobe_n && $past(host_read_strobe_n)
      && $past(host_write_strobe_n) |-> !wait_ready_n_oe;
   endproperty
   a_rdy_idle: assert property (p_rdy_idle) else $error("ready active outside a cycle");
   // The stall must show within a few cycles of the strobe, not only at release.
   property p_wait;
      (wait_mode == 2'h1 && !chip_select_n && !host_read_strobe_n
       && reg_select_addr == 6'h1B && !receive_queue_has_data)[*3] |-> wait_ready_n_oe;
   endproperty
   a_wait: assert property (p_wait) else $error("blocked read not stalled");
   property p_tick;
      timing_tick |=> !timing_tick[*7] ##1 timing_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("timing tick period wrong");
   property p_push;
      $rose(host_write_strobe_n) && !$past(chip_select_n) && $past(reg_select_addr) == 6'h1A
      && $past(transmit_queue_has_room) |-> ##[0:2] tx_queue_push;
   endproperty
   a_push: assert property (p_push) else $error("write not pushed");
   property p_no_push;
      chip_select_n && $past(chip_select_n) && $past(chip_select_n, 2)
      |-> !tx_queue_push && (!rx_queue_pop || !$past(dma_ack_n));
   endproperty
   a_no_push: assert property (p_no_push) else $error("queue touched without select");
   property p_status;
      (!chip_select_n && !host_read_strobe_n && reg_select_addr == 6'h1F)[*2]
      |-> host_data_bus_out == $past(int_cond & int_enable);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");
endmodule
bind schbp_top schbp_checker schbp_checker_inst (.sys_clk(sys_clk), .rst(rst),
   .reg_select_addr(reg_select_addr), .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe(host_data_bus_oe), .host_read_strobe_n(host_read_strobe_n),
   .host_write_strobe_n(host_write_strobe_n), .chip_select_n(chip_select_n),
   .interrupt_ack_n(interrupt_ack_n), .dma_ack_n(dma_ack_n), .wait_ready_n_oe(wait_ready_n_oe),
   .interrupt_request_n_oe(interrupt_request_n_oe), .wait_mode(wait_mode),
   .int_cond(int_cond), .int_enable(int_enable),
   .receive_queue_has_data(receive_queue_has_data),
   .transmit_queue_has_room(transmit_queue_has_room), .rx_queue_pop(rx_queue_pop),
   .tx_queue_push(tx_queue_push), .timing_tick(timing_tick));

// ### test/schbp_host_wire.sv
// Host side wiring model: resolves the data bus and the two open-drain pins.
// Assumes the bench drives the host byte only while it runs a write.
`timescale 1ns/1ps
module schbp_host_wire (
   // Clock.
   input wire sys_clk,
   // Drivers of the data bus.
   input wire [7:0] dev_out,
   input wire dev_oe,
   input wire [7:0] host_out,
   input wire host_wr,
   // Open-drain pulls.
   input wire rdy_oe,
   input wire irq_oe,
   input wire rdy_out,
   input wire irq_out,
   // Resolved levels.
   output wire [7:0] bus,
   output wire rdy_w,
   output wire irq_w
);
   reg [7:0] last_reg = 8'h00;
   // ========================================
   // A floating bus shows the inverse of its last level, so stale data never matches.
   assign bus = (dev_oe && host_wr) ? 8'hXX : dev_oe ? dev_out : host_wr ? host_out : ~last_reg;
   always @(posedge sys_clk) begin
      if (dev_oe || host_wr) last_reg <= bus;
   end
   // Pull-ups hold both pins high unless the device sinks them.
   assign rdy_w = rdy_oe ? rdy_out : 1'h1;
   assign irq_w = irq_oe ? irq_out : 1'h1;
endmodule

// ### test/serial_ctrl_host_bus_port_tb.sv
// Self-checking bench for the host bus port, built from host read and write cycles.
// Assumes the design files and the host wire model are compiled first.
`timescale 1ns/1ps
module serial_ctrl_host_bus_port_tb;
   reg sys_clk = 1'h0, rst = 1'h1, hd = 1'h0, rd_n = 1'h1, wr_n = 1'h1, cs_n = 1'h1;
   reg iack_n = 1'h1, vbs = 1'h0, has_d = 1'h0, room = 1'h1;
   reg [1:0] wmode = 2'h0, akind = 2'h0;
   reg dack_n = 1'h1, ddir = 1'h0;
   reg [7:0] pops = 8'h00;
   reg [5:0] addr = 6'h00;
   reg [7:0] din = 8'h00, cond = 8'h00, en = 8'h00, rxd = 8'h00, ticks = 8'h00, t0, q;
   wire [7:0] dout, bus, txd;
   wire doe, rdy_oe, irq_oe, pop, push, tick, rdy_w, irq_w, rdy_o, irq_o;
   integer errors = 0, samples_checked = 0;
   schbp_top schbp_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_select_addr(addr),
      .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe(doe),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .chip_select_n(cs_n),
      .interrupt_ack_n(iack_n), .dma_ack_n(dack_n), .wait_ready_n_out(rdy_o),
      .wait_ready_n_oe(rdy_oe), .interrupt_request_n_out(irq_o), .interrupt_request_n_oe(irq_oe),
      .wait_mode(wmode), .vector_by_status(vbs), .ack_kind(akind), .dma_rx_dir(ddir),
      .receive_queue_has_data(has_d), .transmit_queue_has_room(room), .int_cond(cond),
      .int_enable(en), .rx_queue_data(rxd), .rx_queue_pop(pop), .tx_queue_push(push),
      .tx_queue_data(txd), .timing_tick(tick));
   schbp_host_wire schbp_host_wire_inst (.sys_clk(sys_clk), .dev_out(dout), .dev_oe(doe),
      .host_out(din), .host_wr(hd), .rdy_oe(rdy_oe), .irq_oe(irq_oe), .bus(bus),
      .rdy_out(rdy_o), .irq_out(irq_o),
      .rdy_w(rdy_w), .irq_w(irq_w));
   // ========================================
   // Clock, tick and pop counters and watchdog; the run needs well under 5000 cycles.
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (tick === 1'h1) ticks <= ticks + 8'h01;
      if (pop === 1'h1) pops <= pops + 8'h01;
   end
   initial begin
      #200000;
      errors = errors + 1;
      final_report;
   end
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One host cycle; strobes stay low until ready is released or 40 cycles pass, then all drop together.
   task acc(input rdop, input c, input [5:0] a, input [7:0] d, output [7:0] r);
      integer n;
      begin
         @(posedge sys_clk);
         cs_n <= c;
         addr <= a;
         din <= d;
         hd <= !rdop;
         if (rdop) rd_n <= 1'h0; else wr_n <= 1'h0;
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         n = 0;
         while (rdy_w !== 1'h1 && n < 40) begin
            @(negedge sys_clk);
            n = n + 1;
         end
         @(negedge sys_clk);
         r = bus;
         @(posedge sys_clk);
         rd_n <= 1'h1;
         wr_n <= 1'h1;
         cs_n <= 1'h1;
         hd <= 1'h0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   task ack(input [1:0] k, input v, input [7:0] eoe, input [7:0] ev);
      begin
         @(posedge sys_clk);
         akind <= k;
         vbs <= v;
         addr <= 6'h1C;
         iack_n <= 1'h0;
         repeat (2) @(negedge sys_clk);
         chk("ack oe", doe, eoe);
         if (eoe == 8'h01) chk("ack data", bus, ev);
         @(posedge sys_clk);
         iack_n <= 1'h1;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   task final_report;
      begin
         $display("errors %0d samples_checked %0d", errors, samples_checked);
         if (errors == 0 && samples_checked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // ========================================
   // Main sequence.
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      repeat (2) @(negedge sys_clk);
      chk("idle oe", doe, 8'h00);
      chk("idle ready", rdy_w, 8'h01);
      acc(1'h0, 1'h0, 6'h05, 8'hA5, q);
      acc(1'h0, 1'h0, 6'h06, 8'h5A, q);
      acc(1'h1, 1'h0, 6'h05, 8'h00, q);
      chk("reg 05", q, 8'hA5);
      acc(1'h1, 1'h0, 6'h06, 8'h00, q);
      chk("reg 06", q, 8'h5A);
      acc(1'h0, 1'h1, 6'h05, 8'h3C, q);
      acc(1'h1, 1'h0, 6'h05, 8'h00, q);
      chk("unselected write", q, 8'hA5);
      @(posedge sys_clk);
      rd_n <= 1'h0;
      cond <= 8'h04;
      repeat (2) @(negedge sys_clk);
      chk("unselected read oe", doe, 8'h00);
      chk("masked irq", irq_w, 8'h01);
      @(posedge sys_clk);
      rd_n <= 1'h1;
      en <= 8'h04;
      repeat (2) @(negedge sys_clk);
      chk("irq", irq_w, 8'h00);
      acc(1'h1, 1'h0, 6'h1F, 8'h00, q);
      chk("status", q, 8'h04);
      acc(1'h0, 1'h0, 6'h1C, 8'h40, q);
      ack(2'h0, 1'h0, 8'h01, 8'h40);
      ack(2'h1, 1'h0, 8'h01, 8'hCD);
      ack(2'h2, 1'h0, 8'h01, 8'h00);
      ack(2'h3, 1'h0, 8'h00, 8'h00);
      ack(2'h0, 1'h1, 8'h01, 8'h42);
      en <= 8'h00;
      ack(2'h0, 1'h0, 8'h00, 8'h00);
      wmode <= 2'h1;
      rxd <= 8'h77;
      fork
         acc(1'h1, 1'h0, 6'h1B, 8'h00, q);
         begin
            repeat (3) @(negedge sys_clk);
            chk("rx stall", rdy_w, 8'h00);
            @(posedge sys_clk);
            has_d <= 1'h1;
         end
      join
      chk("rx data", q, 8'h77);
      chk("rx pop", pops, 8'h01);
      wmode <= 2'h2;
      room <= 1'h0;
      fork
         acc(1'h0, 1'h0, 6'h1A, 8'h99, q);
         begin
            repeat (3) @(negedge sys_clk);
            chk("tx stall", rdy_w, 8'h00);
            @(posedge sys_clk);
            room <= 1'h1;
         end
      join
      chk("tx data", txd, 8'h99);
      wmode <= 2'h0;
      @(posedge sys_clk);
      ddir <= 1'h1;
      dack_n <= 1'h0;
      rd_n <= 1'h0;
      rxd <= 8'h3C;
      repeat (2) @(negedge sys_clk);
      chk("dma oe", doe, 8'h01);
      chk("dma data", bus, 8'h3C);
      @(posedge sys_clk);
      dack_n <= 1'h1;
      rd_n <= 1'h1;
      repeat (2) @(posedge sys_clk);
      chk("dma pop", pops, 8'h02);
      t0 = ticks;
      repeat (80) @(posedge sys_clk);
      chk("tick count", ticks - t0, 8'h0A);
      final_report;
   end
endmodule
